// [rtl/ccr_edge_det.sv]
// Synchroniser and edge detector for one asynchronous comparator output
`timescale 1ns/1ns
module ccr_edge_det
  import ccr_pkg::*;
(
  input  wire logic core_clk,  // System clock
  input  wire logic rst_n,     // Async reset, active low
  input  wire logic raw_in,    // Raw comparator output, asynchronous
  input  wire logic enable,    // Comparator switched on
  ccr_edge_if.det   ev         // Result and edge events
);

  // ==========================================
  // State
  logic sync1_r, sync1_nxt;  // First stage, read only by the second
  logic sync2_r, sync2_nxt;  // Second stage
  logic prev_r,  prev_nxt;   // Last gated result
  logic live;                // Gated result

  // A switched-off core gives no valid result, so it reads as low
  assign live      = sync2_r & enable;
  assign ev.result = live;
  assign ev.rise   = live & ~prev_r;  // RULE_18
  assign ev.fall   = ~live & prev_r;  // RULE_18

  // Next values
  always_comb begin
    sync1_nxt = raw_in;   // RULE_18
    sync2_nxt = sync1_r;
    prev_nxt  = live;
  end

  // Registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r  <= prev_nxt;
    end
  end

  // ==========================================
  // Checks
  sequence raw_goes_high;
    enable && !prev_r && raw_in ##1 enable && raw_in ##1 enable;
  endsequence

  sync_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_18
    raw_goes_high |-> ev.rise || $past(ev.rise) || ev.result)
    else $error("rise not seen two cycles after raw input went high");

endmodule : ccr_edge_det

// [rtl/ccr_edge_if.sv]
// Interface carrying the synchronised comparator result and its edge events
`timescale 1ns/1ns
interface ccr_edge_if;
  logic result;  // Synchronised, enable-gated comparator result
  logic rise;    // One-cycle rising edge event
  logic fall;    // One-cycle falling edge event

  modport det  (output result, output rise, output fall);
  modport user (input result, input rise, input fall);
endinterface : ccr_edge_if

// [rtl/ccr_pkg.sv]
// Package for the comparator control register bank: addresses, fields, resets
package ccr_pkg;
  // ==========================================
  // Register addresses on the special-function bus
  localparam logic [7:0] CCR_ADDR_CMP1_CTRL = 8'h9a;  // Comparator 1 control
  localparam logic [7:0] CCR_ADDR_CMP1_MODE = 8'h9c;  // Comparator 1 mode
  localparam logic [7:0] CCR_ADDR_CMP0_MODE = 8'h9d;  // Comparator 0 mode
  localparam logic [7:0] CCR_ADDR_CMP1_MUX  = 8'h9f;  // Comparator 1 input select

  // ==========================================
  // Reset values
  localparam logic [7:0] CCR_RST_CTRL = 8'h00;  // Off, flags clear, no hysteresis
  localparam logic [7:0] CCR_RST_MODE = 8'h02;  // Interrupts off, speed mode 2
  localparam logic [7:0] CCR_RST_MUX  = 8'hff;  // Both selects reserved

  // ==========================================
  // Field positions
  localparam int CCR_MODE_RSVD    = 7;  // Reserved, reads zero
  localparam int CCR_MODE_UNUSED  = 6;  // Unused, reads zero
  localparam int CCR_MODE_RISE_EN = 5;  // Rising edge interrupt enable
  localparam int CCR_MODE_FALL_EN = 4;  // Falling edge interrupt enable
  localparam int CCR_MODE_GAP_LSB = 2;  // Unused pair, reads zero
  localparam int CCR_MODE_SPD_LSB = 0;  // Response mode select
  localparam int CCR_CTRL_ON      = 7;  // Comparator enable
  localparam int CCR_CTRL_RESULT  = 6;  // Live result, read only
  localparam int CCR_CTRL_RISE    = 5;  // Sticky rising edge flag
  localparam int CCR_CTRL_FALL    = 4;  // Sticky falling edge flag
  localparam int CCR_CTRL_HYP_LSB = 2;  // Positive hysteresis select
  localparam int CCR_CTRL_HYN_LSB = 0;  // Negative hysteresis select
  localparam int CCR_MUX_INV_LSB  = 4;  // Inverting input select
  localparam int CCR_MUX_NON_LSB  = 0;  // Non-inverting input select

  // Writable bits of a mode register; everything else stores zero
  localparam logic [7:0] CCR_MODE_WMASK = 8'h33;
  localparam logic [7:0] CCR_RD_IDLE    = 8'h00;  // Read data when idle or unmapped

  // ==========================================
  // Encodings
  typedef enum logic [1:0] {
    CCR_SPD_FAST = 2'b00,  // Fastest response
    CCR_SPD_M1   = 2'b01,  // Mode 1
    CCR_SPD_M2   = 2'b10,  // Mode 2
    CCR_SPD_LOW  = 2'b11   // Lowest power
  } ccr_speed_t;

  typedef enum logic [1:0] {
    CCR_HYS_OFF = 2'b00,  // Disabled
    CCR_HYS_5   = 2'b01,  // 5 mV
    CCR_HYS_10  = 2'b10,  // 10 mV
    CCR_HYS_20  = 2'b11   // 20 mV
  } ccr_hyst_t;
endpackage : ccr_pkg

// [rtl/ccr_regs.sv]
// Control and status registers for two analog comparators
// Functional notes
// [RULE_01] Mode bit 7 reads zero; write zero
// [RULE_02] Mode bit 6 reads zero, writes ignored
// [RULE_03] Mode bits 3-2 read 00, writes ignored
// [RULE_04] Mode bit 5 enables rising edge interrupt
// [RULE_05] Mode bit 4 enables falling edge interrupt
// [RULE_06] Mode bits 1-0 pick response mode
// [RULE_07] Select bits 7-4 pick inverting input
// [RULE_08] Select bits 3-0 pick non-inverting input
// [RULE_09] Control bit 7 switches comparator on
// [RULE_10] Control bit 6 reads live result
// [RULE_11] Control bit 5 sticky rising edge flag
// [RULE_12] Control bit 4 sticky falling edge flag
// [RULE_13] Control bits 3-2 drive positive hysteresis
// [RULE_14] Control bits 1-0 drive negative hysteresis
// [RULE_15] Flags clear only by software write
// [RULE_16] Disabled comparator drives port output low
// [RULE_17] Software clears flags after settling changes
// [RULE_18] Synchronise output; interrupt on enabled flag
// [RULE_19] Edge wins over same-cycle flag clear
`timescale 1ns/1ns
module ccr_regs
  import ccr_pkg::*;
(
  input  wire logic       core_clk,               // System clock, 50 MHz
  input  wire logic       rst_n,                  // Async reset, active low
  input  wire logic [7:0] sfr_addr,               // Register address
  input  wire logic       sfr_wr,                 // Write strobe, one cycle
  input  wire logic       sfr_rd,                 // Read strobe, one cycle
  input  wire logic [7:0] sfr_wdata,              // Write data
  output logic      [7:0] sfr_rdata,              // Read data, one cycle after strobe
  input  wire logic       cmp1_raw,               // Comparator 1 analog output, async
  input  wire logic       cmp0_rise_flag,         // Comparator 0 rising flag from its control
  input  wire logic       cmp0_fall_flag,         // Comparator 0 falling flag from its control
  output logic            cmp0_irq,               // Comparator 0 interrupt request
  output logic            cmp1_irq,               // Comparator 1 interrupt request
  output logic      [1:0] cmp0_speed_sel,         // Comparator 0 response mode
  output logic      [1:0] cmp1_speed_sel,         // Comparator 1 response mode
  output logic      [3:0] cmp1_inverting_sel,     // Comparator 1 inverting input select
  output logic      [3:0] cmp1_noninverting_sel,  // Comparator 1 non-inverting input select
  output logic            cmp1_on,                // Comparator 1 enable
  output logic      [1:0] cmp1_pos_hyst_sel,      // Comparator 1 positive hysteresis
  output logic      [1:0] cmp1_neg_hyst_sel,      // Comparator 1 negative hysteresis
  output logic            cmp1_port_out           // Comparator 1 output towards port pins
);

  // ==========================================
  // Edge detection
  ccr_edge_if edge1 ();  // Events of comparator 1

  ccr_edge_det u_edge1 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .raw_in   (cmp1_raw),
    .enable   (cmp1_on),
    .ev       (edge1.det)
  );

  // ==========================================
  // Register state
  logic [7:0] mode0_r, mode0_nxt;  // Comparator 0 mode
  logic [7:0] mode1_r, mode1_nxt;  // Comparator 1 mode
  logic [7:0] mux1_r,  mux1_nxt;   // Comparator 1 input select
  logic [7:0] ctrl1_r, ctrl1_nxt;  // Comparator 1 control, result bit held zero
  logic [7:0] rdata_r, rdata_nxt;  // Read data
  logic       irq0_r,  irq0_nxt;   // Comparator 0 request
  logic       irq1_r,  irq1_nxt;   // Comparator 1 request
  logic       port_r,  port_nxt;   // Port output copy

  // Decoded writes
  logic wr_mode0;  // Write to comparator 0 mode
  logic wr_mode1;  // Write to comparator 1 mode
  logic wr_mux1;   // Write to input select
  logic wr_ctrl1;  // Write to control

  assign wr_mode0 = sfr_wr && (sfr_addr == CCR_ADDR_CMP0_MODE);
  assign wr_mode1 = sfr_wr && (sfr_addr == CCR_ADDR_CMP1_MODE);
  assign wr_mux1  = sfr_wr && (sfr_addr == CCR_ADDR_CMP1_MUX);
  assign wr_ctrl1 = sfr_wr && (sfr_addr == CCR_ADDR_CMP1_CTRL);

  // ==========================================
  // Configuration next values
  always_comb begin
    mode0_nxt = mode0_r;
    mode1_nxt = mode1_r;
    mux1_nxt  = mux1_r;
    // Unused and reserved bits are masked so they never store a one
    if (wr_mode0) begin
      mode0_nxt = sfr_wdata & CCR_MODE_WMASK;  // RULE_01 RULE_02 RULE_03
    end
    if (wr_mode1) begin
      mode1_nxt = sfr_wdata & CCR_MODE_WMASK;  // RULE_01 RULE_02 RULE_03
    end
    // Reserved mux codes are stored as written; the analog mux treats them as open
    if (wr_mux1) begin
      mux1_nxt = sfr_wdata;  // RULE_07 RULE_08
    end
  end

  // ==========================================
  // Control next value, flags included
  always_comb begin
    ctrl1_nxt = ctrl1_r;
    if (wr_ctrl1) begin
      // Software may set or clear the flags; the result bit is never stored
      ctrl1_nxt = sfr_wdata;                 // RULE_09 RULE_13 RULE_14
      ctrl1_nxt[CCR_CTRL_RESULT] = 1'b0;     // RULE_10
    end
    // Hardware only ever sets flags, and after the write so an edge wins a clear
    if (edge1.rise) begin
      ctrl1_nxt[CCR_CTRL_RISE] = 1'b1;       // RULE_11 RULE_15 RULE_19
    end
    if (edge1.fall) begin
      ctrl1_nxt[CCR_CTRL_FALL] = 1'b1;       // RULE_12 RULE_15 RULE_19
    end
  end

  // ==========================================
  // Output and read next values
  always_comb begin
    // Request stays high as long as an enabled flag stays set
    irq0_nxt = (cmp0_rise_flag && mode0_r[CCR_MODE_RISE_EN])
             || (cmp0_fall_flag && mode0_r[CCR_MODE_FALL_EN]);  // RULE_04 RULE_05 RULE_18
    irq1_nxt = (ctrl1_r[CCR_CTRL_RISE] && mode1_r[CCR_MODE_RISE_EN])
             || (ctrl1_r[CCR_CTRL_FALL] && mode1_r[CCR_MODE_FALL_EN]);  // RULE_04 RULE_05 RULE_18
    // Disabled comparator presents a low output
    port_nxt = edge1.result && ctrl1_r[CCR_CTRL_ON];  // RULE_16
    rdata_nxt = CCR_RD_IDLE;
    if (sfr_rd) begin
      case (sfr_addr)
        CCR_ADDR_CMP0_MODE: begin
          rdata_nxt = mode0_r;  // RULE_01 RULE_02 RULE_03
        end
        CCR_ADDR_CMP1_MODE: begin
          rdata_nxt = mode1_r;  // RULE_01 RULE_02 RULE_03
        end
        CCR_ADDR_CMP1_MUX: begin
          rdata_nxt = mux1_r;
        end
        CCR_ADDR_CMP1_CTRL: begin
          rdata_nxt = ctrl1_r;
          rdata_nxt[CCR_CTRL_RESULT] = edge1.result;  // RULE_10
        end
        default: begin
          rdata_nxt = CCR_RD_IDLE;  // Unmapped address reads zero
        end
      endcase
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode0_r <= CCR_RST_MODE;
      mode1_r <= CCR_RST_MODE;
      mux1_r  <= CCR_RST_MUX;
      ctrl1_r <= CCR_RST_CTRL;
      rdata_r <= CCR_RD_IDLE;
      irq0_r  <= 1'b0;
      irq1_r  <= 1'b0;
      port_r  <= 1'b0;
    end else begin
      mode0_r <= mode0_nxt;
      mode1_r <= mode1_nxt;
      mux1_r  <= mux1_nxt;
      ctrl1_r <= ctrl1_nxt;
      rdata_r <= rdata_nxt;
      irq0_r  <= irq0_nxt;
      irq1_r  <= irq1_nxt;
      port_r  <= port_nxt;
    end
  end

  // ==========================================
  // Outputs, all straight from flops
  assign sfr_rdata             = rdata_r;
  assign cmp0_irq              = irq0_r;
  assign cmp1_irq              = irq1_r;
  assign cmp0_speed_sel        = mode0_r[CCR_MODE_SPD_LSB +: 2];  // RULE_06
  assign cmp1_speed_sel        = mode1_r[CCR_MODE_SPD_LSB +: 2];  // RULE_06
  assign cmp1_inverting_sel    = mux1_r[CCR_MUX_INV_LSB +: 4];    // RULE_07
  assign cmp1_noninverting_sel = mux1_r[CCR_MUX_NON_LSB +: 4];    // RULE_08
  assign cmp1_on               = ctrl1_r[CCR_CTRL_ON];            // RULE_09
  assign cmp1_pos_hyst_sel     = ctrl1_r[CCR_CTRL_HYP_LSB +: 2];  // RULE_13
  assign cmp1_neg_hyst_sel     = ctrl1_r[CCR_CTRL_HYN_LSB +: 2];  // RULE_14
  assign cmp1_port_out         = port_r;                          // RULE_16

  // ==========================================
  // Checks
  logic rd_mode_q;  // Last cycle read a mode register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_mode_q <= 1'b0;
    end else begin
      rd_mode_q <= sfr_rd && (sfr_addr == CCR_ADDR_CMP0_MODE || sfr_addr == CCR_ADDR_CMP1_MODE);
    end
  end

  sequence clear_rise;
    wr_ctrl1 && !sfr_wdata[CCR_CTRL_RISE];
  endsequence

  sequence rise_event;
    edge1.rise;
  endsequence

  mode_rsvd_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_01
    rd_mode_q |-> !sfr_rdata[CCR_MODE_RSVD])
    else $error("mode reserved bit read as one");

  mode_unused_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_02
    wr_mode0 || wr_mode1 |=> !mode0_r[CCR_MODE_UNUSED] && !mode1_r[CCR_MODE_UNUSED])
    else $error("mode unused bit stored a write");

  mode_gap_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_03
    rd_mode_q |-> sfr_rdata[CCR_MODE_GAP_LSB +: 2] == 2'h0)
    else $error("mode bits 3-2 not zero");

  irq_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_04
    ##1 cmp1_irq == $past((ctrl1_r[CCR_CTRL_RISE] && mode1_r[CCR_MODE_RISE_EN])
                        || (ctrl1_r[CCR_CTRL_FALL] && mode1_r[CCR_MODE_FALL_EN])))
    else $error("interrupt not tied to enabled flags");

  fall_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_05
    !mode1_r[CCR_MODE_FALL_EN] && !mode1_r[CCR_MODE_RISE_EN] ##1 !mode1_r[CCR_MODE_FALL_EN] && !mode1_r[CCR_MODE_RISE_EN]
    |-> !cmp1_irq)
    else $error("interrupt raised while both enables off");

  speed_out_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_06
    wr_mode1 |=> cmp1_speed_sel == $past(sfr_wdata[CCR_MODE_SPD_LSB +: 2]))
    else $error("speed select did not follow write");

  mux_out_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_07
    wr_mux1 |=> {cmp1_inverting_sel, cmp1_noninverting_sel} == $past(sfr_wdata))
    else $error("input select did not follow write");

  on_out_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_09
    wr_ctrl1 |=> cmp1_on == $past(sfr_wdata[CCR_CTRL_ON]))
    else $error("enable did not follow write");

  result_rd_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_10
    sfr_rd && sfr_addr == CCR_ADDR_CMP1_CTRL |=> sfr_rdata[CCR_CTRL_RESULT] == $past(edge1.result))
    else $error("result bit not live on read");

  flag_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_15
    ctrl1_r[CCR_CTRL_RISE] && !wr_ctrl1 |=> ctrl1_r[CCR_CTRL_RISE])
    else $error("rising flag cleared without a write");

  edge_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_19
    rise_event and clear_rise |=> ctrl1_r[CCR_CTRL_RISE])
    else $error("edge lost to same-cycle clear");

  fall_set_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_12
    edge1.fall |=> ctrl1_r[CCR_CTRL_FALL])
    else $error("falling edge not flagged");

  port_low_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_16
    !cmp1_on |=> !cmp1_port_out)
    else $error("port output high while disabled");

  // ==========================================
  // Further checks: comparator 0 gating, second flag, hysteresis
  // A rise with its enable set the cycle after must raise the request two edges on
  sequence rise_flagged;
    rise_event ##1 mode1_r[CCR_MODE_RISE_EN];
  endsequence

  rise_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_18
    rise_flagged |=> cmp1_irq)
    else $error("enabled rising flag gave no request");

  rise_set_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_11
    rise_event |=> ctrl1_r[CCR_CTRL_RISE])
    else $error("rising edge not flagged");

  fall_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_15
    ctrl1_r[CCR_CTRL_FALL] && !wr_ctrl1 |=> ctrl1_r[CCR_CTRL_FALL])
    else $error("falling flag cleared without a write");

  // Comparator 0 flags come from outside; only the gating lives here
  irq0_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_04
    cmp0_rise_flag && mode0_r[CCR_MODE_RISE_EN] |=> cmp0_irq)
    else $error("comparator 0 rising request missing");

  irq0_fall_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_05
    cmp0_fall_flag && mode0_r[CCR_MODE_FALL_EN] |=> cmp0_irq)
    else $error("comparator 0 falling request missing");

  speed0_out_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_06
    wr_mode0 |=> cmp0_speed_sel == $past(sfr_wdata[CCR_MODE_SPD_LSB +: 2]))
    else $error("comparator 0 speed select did not follow write");

  // Hysteresis codes go to the analog core exactly as written
  hyst_pos_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_13
    wr_ctrl1 |=> cmp1_pos_hyst_sel == $past(sfr_wdata[CCR_CTRL_HYP_LSB +: 2]))
    else $error("positive hysteresis did not follow write");

  hyst_neg_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_14
    wr_ctrl1 |=> cmp1_neg_hyst_sel == $past(sfr_wdata[CCR_CTRL_HYN_LSB +: 2]))
    else $error("negative hysteresis did not follow write");

endmodule : ccr_regs

// [verif/ccr_cmp_model.sv]
// Behavioural model of the comparator 1 analog core feeding the register bank
`timescale 1ns/1ns
module ccr_cmp_model (
  input  wire logic       above,      // Plus input above minus input
  input  wire logic       on,         // Enable from the register bank
  input  wire logic [1:0] speed_sel,  // Response mode from the register bank
  output logic            raw         // Asynchronous comparator output
);
  // ==========================================
  // Response delays per mode, in ns
  parameter int T_M0 = 120;   // Fastest response
  parameter int T_M1 = 200;   // Mode 1
  parameter int T_M2 = 360;   // Mode 2
  parameter int T_M3 = 2200;  // Lowest power
  int dly;                    // Delay for the current mode

  // Mode picks the delay
  always_comb begin
    case (speed_sel)
      2'b00:   dly = T_M0;
      2'b01:   dly = T_M1;
      2'b10:   dly = T_M2;
      default: dly = T_M3;
    endcase
  end

  // Output moves off the clock grid; while off it still follows the inputs,
  // so only the bank's gating can hide it
  initial raw = 1'b0;
  always @(above or on) begin
    raw <= #(on ? dly : 7) above;
  end
endmodule : ccr_cmp_model

// [verif/ccr_regs_tb.sv]
// Self-checking testbench for the comparator control register bank
`timescale 1ns/1ns
module ccr_regs_tb
  import ccr_pkg::*;
;
  // ==========================================
  // Signals
  logic       core_clk;        // System clock
  logic       rst_n;           // Reset, active low
  logic [7:0] sfr_addr;        // Register address
  logic       sfr_wr;          // Write strobe
  logic       sfr_rd;          // Read strobe
  logic [7:0] sfr_wdata;       // Write data
  logic [7:0] sfr_rdata;       // Read data
  logic       cmp1_raw;        // Model output
  logic       above;           // Analog condition for the model
  logic       cmp0_rise_flag;  // Comparator 0 flags
  logic       cmp0_fall_flag;
  logic       cmp0_irq;        // Interrupt requests
  logic       cmp1_irq;
  logic [1:0] cmp0_speed_sel;  // Mode selects
  logic [1:0] cmp1_speed_sel;
  logic [3:0] cmp1_inverting_sel;
  logic [3:0] cmp1_noninverting_sel;
  logic       cmp1_on;
  logic [1:0] cmp1_pos_hyst_sel;
  logic [1:0] cmp1_neg_hyst_sel;
  logic       cmp1_port_out;
  int         n_errors;        // Mismatches
  int         checks;          // Comparisons made

  ccr_regs dut (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cmp1_raw(cmp1_raw),
    .cmp0_rise_flag(cmp0_rise_flag), .cmp0_fall_flag(cmp0_fall_flag), .cmp0_irq(cmp0_irq),
    .cmp1_irq(cmp1_irq), .cmp0_speed_sel(cmp0_speed_sel), .cmp1_speed_sel(cmp1_speed_sel),
    .cmp1_inverting_sel(cmp1_inverting_sel), .cmp1_noninverting_sel(cmp1_noninverting_sel),
    .cmp1_on(cmp1_on), .cmp1_pos_hyst_sel(cmp1_pos_hyst_sel),
    .cmp1_neg_hyst_sel(cmp1_neg_hyst_sel), .cmp1_port_out(cmp1_port_out));

  ccr_cmp_model core (.above(above), .on(cmp1_on), .speed_sel(cmp1_speed_sel), .raw(cmp1_raw));

  // ==========================================
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One-cycle write strobe, launched at a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask : wr

  // Read data stands only the cycle after the strobe, so sample it there
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    chk(what, sfr_rdata, exp);
  endtask : rdc

  // Bounded wait for the routed output, then compare
  task automatic wait_port(input logic exp);
    for (int i = 0; i < 200 && cmp1_port_out !== exp; i++) @(negedge core_clk);
    chk("port_out", 8'(cmp1_port_out), 8'(exp));
  endtask : wait_port

  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("speed", {4'h0, cmp1_speed_sel, cmp0_speed_sel}, 8'h0a);
    chk("mux", {cmp1_inverting_sel, cmp1_noninverting_sel}, 8'hff);
    chk("ctl", {cmp1_on, cmp1_pos_hyst_sel, cmp1_neg_hyst_sel, cmp1_port_out, cmp0_irq, cmp1_irq}, 8'h00);
    rdc(CCR_ADDR_CMP1_CTRL, 8'h00, "ctrl");
    rdc(CCR_ADDR_CMP1_MODE, 8'h02, "mode1");
    rdc(CCR_ADDR_CMP0_MODE, 8'h02, "mode0");
    rdc(CCR_ADDR_CMP1_MUX, 8'hff, "mux");
    wr(8'h9b, 8'hff);
    rdc(8'h9b, 8'h00, "unmapped");
  endtask : t_reset

  // Every response mode; bit 7 always written zero, bits 6,3,2 written one
  task automatic t_mode();
    for (int i = 0; i < 4; i++) begin
      wr(CCR_ADDR_CMP1_MODE, 8'h7c | 8'(i));
      rdc(CCR_ADDR_CMP1_MODE, 8'h30 | 8'(i), "mode1");
      chk("speed1", 8'(cmp1_speed_sel), 8'(i));
      wr(CCR_ADDR_CMP0_MODE, 8'h4c | 8'(i));
      rdc(CCR_ADDR_CMP0_MODE, 8'(i), "mode0");
      chk("speed0", 8'(cmp0_speed_sel), 8'(i));
    end
  endtask : t_mode

  // All sixteen codes on both selects, reserved ones included
  task automatic t_mux();
    for (int i = 0; i < 16; i++) begin
      wr(CCR_ADDR_CMP1_MUX, {4'(i), 4'(15 - i)});
      chk("inv", 8'(cmp1_inverting_sel), 8'(i));
      chk("non", 8'(cmp1_noninverting_sel), 8'(15 - i));
    end
  endtask : t_mux

  // Hysteresis codes; the result bit is written one but must read zero while off
  task automatic t_hyst();
    for (int i = 0; i < 4; i++) begin
      wr(CCR_ADDR_CMP1_CTRL, {4'h4, 2'(i), 2'(3 - i)});
      rdc(CCR_ADDR_CMP1_CTRL, {4'h0, 2'(i), 2'(3 - i)}, "ctrl");
      chk("hyp", 8'(cmp1_pos_hyst_sel), 8'(i));
      chk("hyn", 8'(cmp1_neg_hyst_sel), 8'(3 - i));
    end
  endtask : t_hyst

  // Comparator 0 interrupt gating by its mode enables
  task automatic t_irq0();
    wr(CCR_ADDR_CMP0_MODE, 8'h20);
    @(negedge core_clk);
    cmp0_rise_flag = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("irq0", 8'(cmp0_irq), 8'h01);
    cmp0_rise_flag = 1'b0;
    cmp0_fall_flag = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("irq0", 8'(cmp0_irq), 8'h00);
    wr(CCR_ADDR_CMP0_MODE, 8'h10);
    repeat (2) @(negedge core_clk);
    chk("irq0", 8'(cmp0_irq), 8'h01);
    cmp0_fall_flag = 1'b0;
  endtask : t_irq0

  // Edges on comparator 1, sticky flags, interrupt and switch-off
  task automatic t_edges();
    wr(CCR_ADDR_CMP1_MODE, 8'h20);
    wr(CCR_ADDR_CMP1_CTRL, 8'h80);
    chk("on", 8'(cmp1_on), 8'h01);
    wr(CCR_ADDR_CMP1_CTRL, 8'h80);
    above = 1'b1;
    wait_port(1'b1);
    rdc(CCR_ADDR_CMP1_CTRL, 8'he0, "ctrl rise");
    chk("irq1", 8'(cmp1_irq), 8'h01);
    repeat (20) @(negedge core_clk);
    rdc(CCR_ADDR_CMP1_CTRL, 8'he0, "ctrl held");
    wr(CCR_ADDR_CMP1_CTRL, 8'h80);
    rdc(CCR_ADDR_CMP1_CTRL, 8'hc0, "ctrl clr");
    chk("irq1", 8'(cmp1_irq), 8'h00);
    above = 1'b0;
    wait_port(1'b0);
    rdc(CCR_ADDR_CMP1_CTRL, 8'h90, "ctrl fall");
    chk("irq1", 8'(cmp1_irq), 8'h00);
    wr(CCR_ADDR_CMP1_MODE, 8'h10);
    repeat (2) @(negedge core_clk);
    chk("irq1", 8'(cmp1_irq), 8'h01);
    above = 1'b1;
    wait_port(1'b1);
    wr(CCR_ADDR_CMP1_CTRL, 8'h00);
    wait_port(1'b0);
    rdc(CCR_ADDR_CMP1_CTRL, 8'h10, "ctrl off");
  endtask : t_edges

  // Edge and clear land on one clock edge; the edge must win.
  // Model answers in mode 0 after six cycles, the sync adds two more
  task automatic t_race();
    above = 1'b0;
    wr(CCR_ADDR_CMP1_CTRL, 8'h80);
    above = 1'b1;
    repeat (7) @(negedge core_clk);
    wr(CCR_ADDR_CMP1_CTRL, 8'h80);
    rdc(CCR_ADDR_CMP1_CTRL, 8'he0, "ctrl race");
    chk("irq1", 8'(cmp1_irq), 8'h00);
  endtask : t_race

  // Reset again in mid-run, input high
  task automatic t_rerst();
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
  endtask : t_rerst

  // ==========================================
  // Verdict, the one place the run ends
  task automatic stop_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(20 * 20000);
    n_errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    n_errors       = 0;
    checks         = 0;
    rst_n          = 1'b0;
    sfr_addr       = 8'h00;
    sfr_wr         = 1'b0;
    sfr_rd         = 1'b0;
    sfr_wdata      = 8'h00;
    above          = 1'b0;
    cmp0_rise_flag = 1'b0;
    cmp0_fall_flag = 1'b0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    t_mode();
    t_mux();
    t_hyst();
    t_irq0();
    t_edges();
    t_race();
    t_rerst();
    stop_test();
  end
endmodule : ccr_regs_tb
